// [rtl/gpw_pkg.sv]
// gpw_pkg: constants, register map and carrier types of the gpio port block.
// assumes one 50 MHz clock domain and an ahb-lite master on the register side.
package gpw_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_PA_DATA = 8'h00;
	localparam logic [7:0] OFS_PA_DIR = 8'h04;
	localparam logic [7:0] OFS_PA_PU = 8'h08;
	localparam logic [7:0] OFS_PA_WK = 8'h0c;
	localparam logic [7:0] OFS_PB_DATA = 8'h10;
	localparam logic [7:0] OFS_PB_DIR = 8'h14;
	localparam logic [7:0] OFS_PB_PU = 8'h18;
	localparam logic [7:0] OFS_PC_DATA = 8'h1c;
	localparam logic [7:0] OFS_PC_DIR = 8'h20;
	localparam logic [7:0] OFS_PC_PU = 8'h24;
	localparam logic [7:0] OFS_PC_WK = 8'h28;
	localparam logic [7:0] OFS_PD_DATA = 8'h2c;
	localparam logic [7:0] OFS_PD_DIR = 8'h30;
	localparam logic [7:0] OFS_PD_PU = 8'h34;
	localparam logic [7:0] OFS_INT_STS = 8'h38;
	localparam logic [7:0] OFS_INT_EN = 8'h3c;
	localparam logic [7:0] OFS_INT_CLR = 8'h40;

	// shared pin positions
	localparam int INT_PIN_A = 3;
	localparam int TC0_PIN_A = 5;
	localparam int TC1_PIN_C = 5;
	localparam int PFD_PIN_A = 0;
	localparam int CMP_OUT_PIN_C = 7;
	localparam logic [7:0] OPA0_PA_MASK = 8'h1c;
	localparam logic [7:0] OPA1_PA_MASK = 8'h03;
	localparam logic [7:0] OPA1_PC_MASK = 8'h40;

	// pin group carrier, one bit per pin
	typedef struct packed {
		logic [7:0] a;
		logic [5:0] b;
		logic [7:0] c;
		logic [3:0] d;
	} gpw_pins_t;

	typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_RDWAIT, BUS_RDDONE} gpw_bus_t;

	typedef struct packed {
		logic [7:0] pa_lat;
		logic [7:0] pa_dir;
		logic [6:0] pa_pu;
		logic [7:0] pa_wk;
		logic [5:0] pb_lat;
		logic [5:0] pb_dir;
		logic [5:0] pb_pu;
		logic [7:0] pc_lat;
		logic [7:0] pc_dir;
		logic [7:0] pc_pu;
		logic [7:0] pc_wk;
		logic [3:0] pd_lat;
		logic [3:0] pd_dir;
		logic [3:0] pd_pu;
		logic [1:0] int_sts;
		logic [1:0] int_en;
		gpw_pins_t s1;
		gpw_pins_t s2;
		gpw_pins_t prev;
		gpw_pins_t snap;
		logic halted;
		gpw_bus_t ph;
		logic [7:0] addr;
		logic [31:0] hrdata;
	} gpw_state_t;

	// value after reset: latches and directions all ones
	localparam gpw_state_t GPW_ST_RST = '{
		pa_lat: 8'hff, pa_dir: 8'hff, pa_pu: 7'h00, pa_wk: 8'h00,
		pb_lat: 6'h3f, pb_dir: 6'h3f, pb_pu: 6'h00,
		pc_lat: 8'hff, pc_dir: 8'hff, pc_pu: 8'h00, pc_wk: 8'h00,
		pd_lat: 4'hf, pd_dir: 4'hf, pd_pu: 4'h0,
		int_sts: 2'h0, int_en: 2'h0,
		s1: '1, s2: '1, prev: '1, snap: '0,
		halted: 1'b0, ph: BUS_IDLE, addr: 8'h00, hrdata: 32'h0000_0000
	};

endpackage : gpw_pkg

// [rtl/gpw_ports.sv]
// gpw_ports: four gpio ports with pull-ups, wake-up and shared-pin handover.
// assumes an ahb-lite master on hclk and pads that resolve out/oe/pull-up.
`timescale 1ns/1ps
`default_nettype none

module gpw_ports
	import gpw_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire gpw_pins_t pin_in,
	output gpw_pins_t pin_out,
	output gpw_pins_t pin_oe,
	output gpw_pins_t pin_pu,
	input wire logic [3:0] scom_en,
	output logic [3:0] scom_bias,
	input wire logic [1:0] cmp_in_en,
	input wire logic cmp_out_en,
	input wire logic cmp_out,
	input wire logic opa0_en,
	input wire logic opa1_en,
	input wire logic pfd_en,
	input wire logic pfd_clk,
	input wire logic tmr0_ext_mode,
	input wire logic tmr1_ext_mode,
	output logic tmr0_pin,
	output logic tmr1_pin,
	output logic ext_int_n,
	input wire logic halt,
	output logic wake_req,
	output logic irq
);

	gpw_state_t st_ff;
	gpw_state_t nxt_st;
	logic [7:0] pa_ana;
	logic [7:0] pc_ana;
	logic [7:0] pc_cmp;
	logic [7:0] fall_a;
	logic [7:0] fall_c;
	logic take;

	// input bits read the synchronised pin, output bits the latch
	function automatic logic [7:0] rd_port(input logic [7:0] dir, input logic [7:0] lat,
		input logic [7:0] pin);
		return (dir & pin) | (~dir & lat);
	endfunction : rd_port

	// -------------------------------------------------------------
	// pin-shared analog selections
	// -------------------------------------------------------------
	always_comb begin
		pa_ana = (opa0_en ? OPA0_PA_MASK : 8'h00) | (opa1_en ? OPA1_PA_MASK : 8'h00);
		pc_ana = opa1_en ? OPA1_PC_MASK : 8'h00;
		pc_cmp = {6'h00, cmp_in_en};
	end

	// -------------------------------------------------------------
	// pad control
	// -------------------------------------------------------------
	// pull-ups only on inputs, never on analog, comparator or common pins
	always_comb begin
		pin_pu.a = {1'b0, st_ff.pa_pu} & st_ff.pa_dir & ~pa_ana;
		pin_pu.b = st_ff.pb_pu & st_ff.pb_dir & ~{2'b00, scom_en};
		pin_pu.c = st_ff.pc_pu & st_ff.pc_dir & ~pc_ana & ~pc_cmp;
		pin_pu.d = st_ff.pd_pu & st_ff.pd_dir;
	end

	// drivers: direction 0 drives; bit 7 of port a only ever pulls low
	always_comb begin
		pin_oe.a = ~st_ff.pa_dir & ~pa_ana;
		pin_oe.a[7] = ~st_ff.pa_dir[7] & ~st_ff.pa_lat[7];
		pin_oe.b = ~st_ff.pb_dir & ~{2'b00, scom_en};
		pin_oe.c = ~st_ff.pc_dir & ~pc_ana & ~pc_cmp;
		pin_oe.d = ~st_ff.pd_dir;
		pin_out.a = st_ff.pa_lat;
		pin_out.a[7] = 1'b0;
		// divider only reaches the pad through an output direction
		if (pfd_en) begin
			pin_out.a[PFD_PIN_A] = pfd_clk;
		end
		pin_out.b = st_ff.pb_lat;
		pin_out.c = st_ff.pc_lat;
		if (cmp_out_en) begin
			pin_out.c[CMP_OUT_PIN_C] = cmp_out;
		end
		pin_out.d = st_ff.pd_lat;
		scom_bias = scom_en;
	end

	// -------------------------------------------------------------
	// peripheral inputs
	// -------------------------------------------------------------
	// the pins keep their i/o role; peripherals only see input pins
	always_comb begin
		ext_int_n = st_ff.pa_dir[INT_PIN_A] ? st_ff.s2.a[INT_PIN_A] : 1'b1;
		tmr0_pin = tmr0_ext_mode & st_ff.pa_dir[TC0_PIN_A] & st_ff.s2.a[TC0_PIN_A];
		tmr1_pin = tmr1_ext_mode & st_ff.pc_dir[TC1_PIN_C] & st_ff.s2.c[TC1_PIN_C];
	end

	// -------------------------------------------------------------
	// wake-up and events
	// -------------------------------------------------------------
	// clock is stopped while halted, so the request is pure gates against
	// the level caught before halt; a glitch may wake early, never late
	always_comb begin
		wake_req = st_ff.halted & (|(st_ff.pa_wk & st_ff.snap.a & ~pin_in.a)
			| |(st_ff.pc_wk & st_ff.snap.c & ~pin_in.c));
		fall_a = st_ff.prev.a & ~st_ff.s2.a & st_ff.pa_wk;
		fall_c = st_ff.prev.c & ~st_ff.s2.c & st_ff.pc_wk;
		irq = |(st_ff.int_sts & st_ff.int_en);
	end

	// -------------------------------------------------------------
	// bus answer
	// -------------------------------------------------------------
	always_comb begin
		take = hsel & htrans[1] & hready;
		hreadyout = (st_ff.ph != BUS_RDWAIT);
		hresp = 1'b0;
		hrdata = st_ff.hrdata;
	end

	// -------------------------------------------------------------
	// next state
	// -------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		// inputs are not latched: two flops then read live every cycle
		nxt_st.s1 = pin_in;
		nxt_st.s2 = st_ff.s1;
		nxt_st.prev = st_ff.s2;
		nxt_st.halted = halt;
		if (!st_ff.halted) begin
			nxt_st.snap = st_ff.s2;
		end
		// data phase of a write; whole-byte replace, no single-bit update
		if (st_ff.ph == BUS_WRITE) begin
			case (st_ff.addr)
				OFS_PA_DATA: nxt_st.pa_lat = hwdata[7:0];
				OFS_PA_DIR: nxt_st.pa_dir = hwdata[7:0];
				OFS_PA_PU: nxt_st.pa_pu = hwdata[6:0];
				OFS_PA_WK: nxt_st.pa_wk = hwdata[7:0];
				OFS_PB_DATA: nxt_st.pb_lat = hwdata[5:0];
				OFS_PB_DIR: nxt_st.pb_dir = hwdata[5:0];
				OFS_PB_PU: nxt_st.pb_pu = hwdata[5:0];
				OFS_PC_DATA: nxt_st.pc_lat = hwdata[7:0];
				OFS_PC_DIR: nxt_st.pc_dir = hwdata[7:0];
				OFS_PC_PU: nxt_st.pc_pu = hwdata[7:0];
				OFS_PC_WK: nxt_st.pc_wk = hwdata[7:0];
				OFS_PD_DATA: nxt_st.pd_lat = hwdata[3:0];
				OFS_PD_DIR: nxt_st.pd_dir = hwdata[3:0];
				OFS_PD_PU: nxt_st.pd_pu = hwdata[3:0];
				OFS_INT_EN: nxt_st.int_en = hwdata[1:0];
				OFS_INT_CLR: nxt_st.int_sts = st_ff.int_sts & ~hwdata[1:0];
				default: nxt_st.addr = st_ff.addr;
			endcase
		end
		// new edges set after the clear so a same-cycle event survives
		nxt_st.int_sts = nxt_st.int_sts | {|fall_c, |fall_a};
		// read data is formed one cycle after the address phase
		if (st_ff.ph == BUS_RDWAIT) begin
			nxt_st.hrdata = 32'h0000_0000;
			case (st_ff.addr)
				OFS_PA_DATA: nxt_st.hrdata[7:0] = rd_port(st_ff.pa_dir, st_ff.pa_lat,
					st_ff.s2.a & ~pa_ana);
				OFS_PA_DIR: nxt_st.hrdata[7:0] = st_ff.pa_dir;
				OFS_PA_PU: nxt_st.hrdata[6:0] = st_ff.pa_pu;
				OFS_PA_WK: nxt_st.hrdata[7:0] = st_ff.pa_wk;
				OFS_PB_DATA: nxt_st.hrdata[5:0] = 6'(rd_port({2'b00, st_ff.pb_dir},
					{2'b00, st_ff.pb_lat}, {2'b00, st_ff.s2.b}));
				OFS_PB_DIR: nxt_st.hrdata[5:0] = st_ff.pb_dir;
				OFS_PB_PU: nxt_st.hrdata[5:0] = st_ff.pb_pu;
				OFS_PC_DATA: nxt_st.hrdata[7:0] = rd_port(st_ff.pc_dir, st_ff.pc_lat,
					st_ff.s2.c & ~pc_ana);
				OFS_PC_DIR: nxt_st.hrdata[7:0] = st_ff.pc_dir;
				OFS_PC_PU: nxt_st.hrdata[7:0] = st_ff.pc_pu;
				OFS_PC_WK: nxt_st.hrdata[7:0] = st_ff.pc_wk;
				OFS_PD_DATA: nxt_st.hrdata[3:0] = 4'(rd_port({4'h0, st_ff.pd_dir},
					{4'h0, st_ff.pd_lat}, {4'h0, st_ff.s2.d}));
				OFS_PD_DIR: nxt_st.hrdata[3:0] = st_ff.pd_dir;
				OFS_PD_PU: nxt_st.hrdata[3:0] = st_ff.pd_pu;
				OFS_INT_STS: nxt_st.hrdata[1:0] = st_ff.int_sts;
				OFS_INT_EN: nxt_st.hrdata[1:0] = st_ff.int_en;
				default: nxt_st.hrdata = 32'h0000_0000;
			endcase
		end
		// bus phase sequencing; reads insert one wait state
		case (st_ff.ph)
			BUS_RDWAIT: nxt_st.ph = BUS_RDDONE;
			BUS_IDLE, BUS_WRITE, BUS_RDDONE: begin
				if (take) begin
					nxt_st.addr = haddr[7:0];
					nxt_st.ph = hwrite ? BUS_WRITE : BUS_RDWAIT;
				end else begin
					nxt_st.ph = BUS_IDLE;
				end
			end
			default: nxt_st.ph = BUS_IDLE;
		endcase
		// only aligned words in the low page decode
		if (take && (haddr[31:8] != 24'h00_0000 || haddr[1:0] != 2'b00)) begin
			nxt_st.addr = 8'hff;
		end
	end

	// -------------------------------------------------------------
	// state register
	// -------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= GPW_ST_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	pu_input_only_a: assert property ((pin_pu.a & ~st_ff.pa_dir) == 8'h00 && (pin_pu.c & ~st_ff.pc_dir) == 8'h00)
		else $error("pull-up on an output pin");
	pa7_no_pullup_a: assert property (!pin_pu.a[7] && !(st_ff.ph == BUS_RDDONE && st_ff.addr == OFS_PA_PU && hrdata[7]))
		else $error("port a bit 7 pull-up present");
	wake_fall_a: assert property ((st_ff.halted && (st_ff.pa_wk & st_ff.snap.a & ~pin_in.a) != 8'h00) |-> wake_req)
		else $error("wake edge missed");
	wake_edge_sts_a: assert property ((st_ff.prev.c & ~st_ff.s2.c & st_ff.pc_wk) != 8'h00 |=> st_ff.int_sts[1])
		else $error("port c wake edge lost");
	read_input_a: assert property ((st_ff.ph == BUS_RDWAIT && st_ff.addr == OFS_PC_DATA && !opa1_en)
		|=> (hrdata[7:0] & $past(st_ff.pc_dir)) == ($past(st_ff.s2.c) & $past(st_ff.pc_dir)))
		else $error("input read not the pin");
	read_latch_a: assert property ((st_ff.ph == BUS_RDWAIT && st_ff.addr == OFS_PD_DATA)
		|=> (hrdata[3:0] & ~$past(st_ff.pd_dir)) == ($past(st_ff.pd_lat) & ~$past(st_ff.pd_dir)))
		else $error("output read not the latch");
	latch_hold_a: assert property (!(st_ff.ph == BUS_WRITE && st_ff.addr == OFS_PC_DATA) |=> $stable(st_ff.pc_lat))
		else $error("latch changed without write");
	pfd_input_a: assert property ((pfd_en && st_ff.pa_dir[PFD_PIN_A]) |-> !pin_oe.a[PFD_PIN_A])
		else $error("divider drives an input pin");
	timer_gate_a: assert property ((!tmr0_ext_mode || !st_ff.pa_dir[TC0_PIN_A]) |-> !tmr0_pin)
		else $error("timer pin passed while gated");
	cmp_pu_off_a: assert property ((pin_pu.c & {6'h00, cmp_in_en}) == 8'h00)
		else $error("comparator pin keeps pull-up");
	opa_off_a: assert property (((pin_oe.a | pin_pu.a) & pa_ana) == 8'h00)
		else $error("op-amp pin keeps digital path");
	rd_wait_a: assert property ((take && !hwrite && hreadyout) |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

	rd_cov_c: cover property (st_ff.ph == BUS_RDDONE && st_ff.addr == OFS_PA_DATA);
	wr_cov_c: cover property (st_ff.ph == BUS_WRITE && st_ff.addr == OFS_PC_DIR);
	wake_cov_c: cover property (wake_req);
	irq_cov_c: cover property (irq);

endmodule : gpw_ports

`default_nettype wire

// [test/gpw_switches.sv]
// gpw_switches: switches and wiring outside the port pins.
// assumes the pad resolves oe, out and pull-up; the bench sets switch levels.
`timescale 1ns/1ps
`default_nettype none

module gpw_switches
	import gpw_pkg::*;
(
	input wire logic hclk,
	input wire gpw_pins_t pin_out,
	input wire gpw_pins_t pin_oe,
	input wire gpw_pins_t pin_pu,
	input wire gpw_pins_t sw_val,
	input wire gpw_pins_t sw_en,
	input wire gpw_pins_t sw_force,
	output wire gpw_pins_t pin_in
);
	gpw_pins_t float_ff = '0;

	// a floating pin wanders each cycle, so a stale level never passes for a read
	always_ff @(posedge hclk) begin
		float_ff <= ~float_ff;
	end

	// force models a hard short fighting an output; switches hold levels steady
	assign pin_in = (sw_force & sw_val) | (~sw_force & pin_oe & pin_out)
		| (~sw_force & ~pin_oe & sw_en & sw_val)
		| (~sw_force & ~pin_oe & ~sw_en & pin_pu)
		| (~sw_force & ~pin_oe & ~sw_en & ~pin_pu & float_ff);
endmodule : gpw_switches
`default_nettype wire

// [test/gpio_ports_pullup_wake_test.sv]
// gpio_ports_pullup_wake_test: self-checking bench of the gpio port block.
// assumes gpw_ports as the one ahb-lite slave and gpw_switches on its pins.
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module gpio_ports_pullup_wake_test
	import gpw_pkg::*;
;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, clk_run;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, cmp_in_en;
	gpw_pins_t pin_in, pin_out, pin_oe, pin_pu, sw_val, sw_en, sw_force;
	logic [3:0] scom_en, scom_bias;
	logic opa0_en, opa1_en, pfd_en, pfd_clk, tmr0_ext_mode, tmr1_ext_mode;
	logic tmr0_pin, tmr1_pin, ext_int_n, halt, wake_req, irq;
	int err_count, checked, cyc;

	gpw_ports u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu),
		.scom_en(scom_en), .scom_bias(scom_bias), .cmp_in_en(cmp_in_en),
		.cmp_out_en(1'b0), .cmp_out(1'b0), .opa0_en(opa0_en), .opa1_en(opa1_en),
		.pfd_en(pfd_en), .pfd_clk(pfd_clk), .tmr0_ext_mode(tmr0_ext_mode),
		.tmr1_ext_mode(tmr1_ext_mode), .tmr0_pin(tmr0_pin), .tmr1_pin(tmr1_pin),
		.ext_int_n(ext_int_n), .halt(halt), .wake_req(wake_req), .irq(irq));
	gpw_switches u_sw (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pu(pin_pu), .sw_val(sw_val), .sw_en(sw_en), .sw_force(sw_force),
		.pin_in(pin_in));

	// --------------------------------------------------------------
	// clock, watchdog and verdict
	// --------------------------------------------------------------
	// the clock can be stopped to mimic the halted core
	initial begin
		hclk = 1'b0;
		forever begin
			#10;
			if (clk_run) hclk = ~hclk;
		end
	end

	// the whole run needs a few hundred cycles; far beyond that is a hang
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict

	// --------------------------------------------------------------
	// ahb-lite master
	// --------------------------------------------------------------
	// ready and read data are taken at the rising edge that sees ready high
	task automatic wait_rdy(output logic [31:0] d);
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			@(posedge hclk);
		end
		d = hrdata;
	endtask : wait_rdy

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd_d);
		logic [31:0] x;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		wait_rdy(x);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		wait_rdy(rd_d);
		#1;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		bus(1'b0, a, 32'h0, d);
	endtask : rd

	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask : tick

	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] d;
		logic [7:0] ofs [10] = '{OFS_PA_DIR, OFS_PB_DIR, OFS_PC_DIR, OFS_PD_DIR,
			OFS_PA_PU, OFS_PB_PU, OFS_PC_PU, OFS_PD_PU, OFS_PA_WK, OFS_PC_WK};
		logic [7:0] ev [10] = '{8'hff, 8'h3f, 8'hff, 8'h0f, 0, 0, 0, 0, 0, 0};
		`CHK(pin_oe, 26'h0)
		`CHK(pin_pu, 26'h0)
		`CHK(pin_out.c, 8'hff)
		for (int i = 0; i < 10; i++) begin
			rd(ofs[i], d);
			`CHK(d, {24'h0, ev[i]})
		end
		rd(OFS_PA_DATA, d);
		`CHK(d, 32'hff)
		$display("test reset done");
	endtask : t_reset

	task automatic t_dir_pullup();
		logic [31:0] d;
		wr(OFS_PA_PU, 32'hff);
		rd(OFS_PA_PU, d);
		`CHK(d, 32'h7f)
		`CHK(pin_pu.a, 8'h7f)
		wr(OFS_PA_DIR, 32'hf0);
		`CHK(pin_pu.a, 8'h70)
		`CHK(pin_oe.a, 8'h0f)
		`CHK(pin_out.a[3:0], 4'hf)
		wr(OFS_PA_DATA, 32'h5a);
		wr(OFS_PC_DATA, 32'h00);
		`CHK(pin_out.a[3:0], 4'ha)
		// a short drags the outputs the other way; reads must still show the latch
		sw_force.a <= 8'h0f;
		sw_val.a <= 8'h35;
		tick(4);
		rd(OFS_PA_DATA, d);
		`CHK(d, 32'h3a)
		sw_force.a <= 8'h00;
		sw_val.a <= 8'hff;
		// bit clear done by software: read, modify one bit, write the byte back
		rd(OFS_PA_DIR, d);
		wr(OFS_PA_DIR, d & ~32'h10);
		`CHK(pin_oe.a, 8'h1f)
		wr(OFS_PA_DIR, 32'hff);
		$display("test direction and pull-up done");
	endtask : t_dir_pullup

	task automatic t_wake();
		logic [31:0] d;
		wr(OFS_PA_WK, 32'h84);
		wr(OFS_PC_WK, 32'h01);
		rd(OFS_PA_WK, d);
		`CHK(d, 32'h84)
		halt <= 1'b1;
		tick(3);
		clk_run = 1'b0;
		#50 sw_val.a[3] = 1'b0;
		#5 `CHK(wake_req, 1'b0)
		sw_val.a[2] = 1'b0;
		#5 `CHK(wake_req, 1'b1)
		sw_val.a = 8'hff;
		#5 `CHK(wake_req, 1'b0)
		sw_val.c[0] = 1'b0;
		#5 `CHK(wake_req, 1'b1)
		sw_val.c = 8'hff;
		clk_run = 1'b1;
		@(posedge hclk);
		halt <= 1'b0;
		$display("test wake done");
	endtask : t_wake

	task automatic t_irq();
		logic [31:0] d;
		wr(OFS_INT_CLR, 32'h3);
		wr(OFS_INT_EN, 32'h1);
		sw_val.a[2] <= 1'b0;
		tick(6);
		`CHK(irq, 1'b1)
		wr(OFS_INT_EN, 32'h0);
		`CHK(irq, 1'b0)
		rd(OFS_INT_STS, d);
		`CHK(d, 32'h1)
		wr(OFS_INT_CLR, 32'h1);
		rd(OFS_INT_STS, d);
		`CHK(d, 32'h0)
		sw_val.c[0] <= 1'b0;
		wr(OFS_INT_EN, 32'h2);
		`CHK(irq, 1'b1)
		wr(OFS_INT_CLR, 32'h2);
		`CHK(irq, 1'b0)
		sw_val <= '1;
		wr(8'h80, 32'hffff_ffff);
		rd(8'h80, d);
		`CHK(d, 32'h0)
		$display("test interrupt done");
	endtask : t_irq

	task automatic t_shared();
		logic [31:0] d;
		sw_val.a[3] <= 1'b0;
		tmr0_ext_mode <= 1'b1;
		tmr1_ext_mode <= 1'b1;
		tick(4);
		`CHK(ext_int_n, 1'b0)
		`CHK({tmr0_pin, tmr1_pin}, 2'b11)
		wr(OFS_PA_DIR, 32'hd7);
		`CHK({ext_int_n, tmr0_pin}, 2'b10)
		tmr1_ext_mode <= 1'b0;
		pfd_en <= 1'b1;
		pfd_clk <= 1'b1;
		tick(4);
		`CHK(tmr1_pin, 1'b0)
		`CHK(pin_oe.a[0], 1'b0)
		wr(OFS_PA_DIR, 32'hfe);
		`CHK({pin_oe.a[0], pin_out.a[0]}, 2'b11)
		pfd_clk <= 1'b0;
		tick(1);
		`CHK(pin_out.a[0], 1'b0)
		for (int i = 0; i < 16; i++) begin
			scom_en <= 4'(i);
			tick(1);
			`CHK(scom_bias, 4'(i))
		end
		wr(OFS_PC_PU, 32'hff);
		cmp_in_en <= 2'b11;
		tick(1);
		`CHK(pin_pu.c, 8'hfc)
		opa1_en <= 1'b1;
		tick(1);
		`CHK(pin_pu.c, 8'hbc)
		`CHK(pin_pu.a[1:0], 2'b00)
		opa1_en <= 1'b0;
		opa0_en <= 1'b1;
		wr(OFS_PA_DIR, 32'h00);
		`CHK(pin_oe.a[4:2], 3'b000)
		wr(OFS_PA_DIR, 32'hff);
		`CHK(pin_pu.a[4:2], 3'b000)
		rd(OFS_PA_DATA, d);
		`CHK(d[4:2], 3'b000)
		$display("test shared pins done");
	endtask : t_shared

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{cmp_in_en, scom_en, opa0_en, opa1_en, pfd_en, pfd_clk, halt} = '0;
		{tmr0_ext_mode, tmr1_ext_mode, err_count, checked, cyc} = '0;
		clk_run = 1'b1;
		sw_val = '1;
		sw_en = '1;
		sw_force = '0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		tick(1);
		t_reset();
		t_dir_pullup();
		t_wake();
		t_irq();
		t_shared();
		give_verdict();
	end
endmodule : gpio_ports_pullup_wake_test
`default_nettype wire
